/* File: hdl/ltm_top.sv */
// line test mode control: mode selection, line and indication control, APB registers
// assumes pins and command strobes are synchronous to clk_i, APB on the same clock
`timescale 1ns/10ps

// Overview of operation
// R1 - in single pulse mode the line carries isolated plus three and minus three pulses alternately, 1.5 ms apart.
// R2 - single pulse mode is chosen by both pins high, by command 0101, or by both register bits set.
// R3 - the chosen mode acts the same whichever of pins, command or register bits chose it.
// R4 - in single pulse mode the idle indication goes upstream in line termination and the shutdown request in network termination.
// R5 - single pulse and data through modes work in both line and network termination configurations.
// R6 - choosing data through mode forces the activation machine straight into transparent from any state.
// R7 - data through mode sends normal scrambled line data with no wake-up handshake.
// R8 - data through mode is chosen by quiet reset low with test select high, by command 0110, or by bit one clear with bit two set.
// R9 - master reset mode enters the test state, silences the line and clears all canceller and equalizer coefficients.
// R10 - in the test state every activation attempt is refused in either configuration.
// R11 - master reset mode is chosen by both pins low or by command 0001.
// R12 - in the test state the idle indication goes upstream in line termination and the shutdown request in network termination.
// R13 - with no test mode chosen the device runs normally and leaves line transmission untouched.
module ltm_top #(
    parameter int PULSE_CYCLES = ltm_pkg::PULSE_SPACING_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // test pins
    input  wire logic        quiet_reset_input_i,
    input  wire logic        test_select_input_i,
    // command channel
    input  wire logic        ci_cmd_valid_i,
    input  wire logic [3:0]  ci_cmd_i,
    // indication channel
    output logic             ci_override_o,
    output logic [3:0]       ci_ind_o,
    // line and state machine control
    output logic [1:0]       test_mode_o,
    output logic             tx_mute_o,
    output logic             tx_single_pulse_o,
    output logic             pulse_strobe_o,
    output logic [2:0]       pulse_level_o,
    output logic             wakeup_bypass_o,
    output logic             force_transparent_o,
    output logic             coef_clear_o,
    output logic             activation_block_o
);

    typedef struct packed {
        logic              tm1;
        logic              tm2;
        logic              nt;
        ltm_pkg::ltm_mode_t cmd_mode;
        ltm_pkg::ltm_mode_t mode;
        logic              force_tr;
        logic              coef_clr;
        logic              ovr;
        logic [3:0]        ind;
        logic [31:0]       prdata;
        logic              pslverr;
    } ltm_state_t;

    ltm_state_t         s_q;
    ltm_state_t         s_d;
    ltm_pkg::ltm_mode_t pin_mode;
    ltm_pkg::ltm_mode_t reg_mode;
    ltm_pkg::ltm_mode_t sel_mode;
    logic               setup_ph;
    logic               access_ph;
    logic               hit_test;
    logic               hit_stat;

    // pin decode; quiet reset high with test select low means no test
    always_comb
    begin
        if (quiet_reset_input_i && test_select_input_i)
        begin
            pin_mode = ltm_pkg::MODE_SINGLE_PULSE; // see R2
        end
        else if (!quiet_reset_input_i && test_select_input_i)
        begin
            pin_mode = ltm_pkg::MODE_DATA_THROUGH; // see R8
        end
        else if (!quiet_reset_input_i && !test_select_input_i)
        begin
            pin_mode = ltm_pkg::MODE_MASTER_RESET; // see R11
        end
        else
        begin
            pin_mode = ltm_pkg::MODE_NORMAL;
        end
    end

    // register bit decode; master reset has no register selection
    always_comb
    begin
        if (s_q.tm1 && s_q.tm2)
        begin
            reg_mode = ltm_pkg::MODE_SINGLE_PULSE; // see R2
        end
        else if (!s_q.tm1 && s_q.tm2)
        begin
            reg_mode = ltm_pkg::MODE_DATA_THROUGH; // see R8
        end
        else
        begin
            reg_mode = ltm_pkg::MODE_NORMAL;
        end
    end

    // one resolved mode drives everything, so the source is invisible downstream
    always_comb
    begin
        if (pin_mode != ltm_pkg::MODE_NORMAL)
        begin
            sel_mode = pin_mode; // see R3
        end
        else if (reg_mode != ltm_pkg::MODE_NORMAL)
        begin
            sel_mode = reg_mode; // see R3
        end
        else
        begin
            sel_mode = s_q.cmd_mode; // see R3, see R13
        end
    end

    assign setup_ph  = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign hit_test  = paddr_i == ltm_pkg::ADDR_SYSTEM_TEST;
    assign hit_stat  = paddr_i == ltm_pkg::ADDR_STATUS;

    always_comb
    begin
        s_d          = s_q;
        s_d.force_tr = 1'b0;
        s_d.coef_clr = 1'b0;

        // last command code received holds its mode; any other code ends it
        if (ci_cmd_valid_i)
        begin
            case (ci_cmd_i)
                ltm_pkg::CMD_SINGLE_PULSE: s_d.cmd_mode = ltm_pkg::MODE_SINGLE_PULSE; // see R2
                ltm_pkg::CMD_DATA_THROUGH: s_d.cmd_mode = ltm_pkg::MODE_DATA_THROUGH; // see R8
                ltm_pkg::CMD_LINE_SILENCE: s_d.cmd_mode = ltm_pkg::MODE_MASTER_RESET; // see R11
                default:                   s_d.cmd_mode = ltm_pkg::MODE_NORMAL;
            endcase
        end

        s_d.mode = sel_mode;
        case (sel_mode)
            ltm_pkg::MODE_DATA_THROUGH:
            begin
                s_d.force_tr = s_q.mode != ltm_pkg::MODE_DATA_THROUGH; // see R6
            end
            ltm_pkg::MODE_MASTER_RESET:
            begin
                s_d.coef_clr = s_q.mode != ltm_pkg::MODE_MASTER_RESET; // see R9
            end
            default:
            begin
                s_d.force_tr = 1'b0;
            end
        endcase

        // indication override; both configurations handled alike otherwise
        s_d.ovr = sel_mode == ltm_pkg::MODE_SINGLE_PULSE ||
                  sel_mode == ltm_pkg::MODE_MASTER_RESET; // see R4, see R12
        s_d.ind = s_d.ovr ? (s_q.nt ? ltm_pkg::IND_SHUTDOWN_REQ : ltm_pkg::IND_LINE_IDLE)
                          : ltm_pkg::IND_LINE_IDLE; // see R4, see R12, see R5

        // apb: read data and error latched in the setup cycle, write at the access edge
        if (setup_ph)
        begin
            s_d.pslverr = !(hit_test || hit_stat);
            s_d.prdata  = '0;
            if (hit_test)
            begin
                s_d.prdata[ltm_pkg::BIT_TEST_MODE_ONE] = s_q.tm1;
                s_d.prdata[ltm_pkg::BIT_TEST_MODE_TWO] = s_q.tm2;
                s_d.prdata[ltm_pkg::BIT_NT_CONFIG]     = s_q.nt;
            end
            else if (hit_stat)
            begin
                s_d.prdata[ltm_pkg::STAT_MODE_LSB +: 2] = s_q.mode;
                s_d.prdata[ltm_pkg::STAT_BLOCK_BIT]     = s_q.mode == ltm_pkg::MODE_MASTER_RESET;
                s_d.prdata[ltm_pkg::STAT_IND_LSB +: 4]  = s_q.ind;
            end
        end
        if (access_ph && pwrite_i && hit_test)
        begin
            s_d.tm1 = pwdata_i[ltm_pkg::BIT_TEST_MODE_ONE];
            s_d.tm2 = pwdata_i[ltm_pkg::BIT_TEST_MODE_TWO];
            s_d.nt  = pwdata_i[ltm_pkg::BIT_NT_CONFIG];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_q          <= '0;
            s_q.tm1      <= ltm_pkg::SYSTEM_TEST_RST[ltm_pkg::BIT_TEST_MODE_ONE];
            s_q.tm2      <= ltm_pkg::SYSTEM_TEST_RST[ltm_pkg::BIT_TEST_MODE_TWO];
            s_q.nt       <= ltm_pkg::SYSTEM_TEST_RST[ltm_pkg::BIT_NT_CONFIG];
            s_q.cmd_mode <= ltm_pkg::MODE_NORMAL;
            s_q.mode     <= ltm_pkg::MODE_NORMAL;
            s_q.ind      <= ltm_pkg::IND_LINE_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // enable follows the resolved mode, so no strobe lands after the mode is left
    ltm_pulse_gen #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_pulse (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .en_i    (sel_mode == ltm_pkg::MODE_SINGLE_PULSE), // see R1, see R13
        .pulse_o (pulse_strobe_o),
        .level_o (pulse_level_o)
    );

    assign pready_o            = 1'b1;
    assign prdata_o            = s_q.prdata;
    assign pslverr_o           = access_ph && s_q.pslverr;
    assign test_mode_o         = s_q.mode;
    assign ci_override_o       = s_q.ovr;
    assign ci_ind_o            = s_q.ind;
    assign tx_mute_o           = s_q.mode == ltm_pkg::MODE_MASTER_RESET; // see R9
    assign tx_single_pulse_o   = s_q.mode == ltm_pkg::MODE_SINGLE_PULSE; // see R1
    assign wakeup_bypass_o     = s_q.mode == ltm_pkg::MODE_DATA_THROUGH; // see R7
    assign force_transparent_o = s_q.force_tr; // see R6
    assign coef_clear_o        = s_q.coef_clr; // see R9
    assign activation_block_o  = s_q.mode == ltm_pkg::MODE_MASTER_RESET; // see R10

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_sp_pins;
        quiet_reset_input_i && test_select_input_i |=>
            test_mode_o == ltm_pkg::MODE_SINGLE_PULSE && tx_single_pulse_o;
    endproperty
    a_sp_pins: assert property (p_sp_pins) // see R2
        else $error("pins did not select single pulse mode");

    property p_dt_reg;
        quiet_reset_input_i && !test_select_input_i && !s_q.tm1 && s_q.tm2 |=>
            test_mode_o == ltm_pkg::MODE_DATA_THROUGH;
    endproperty
    a_dt_reg: assert property (p_dt_reg) // see R8, see R3
        else $error("register bits did not select data through mode");

    property p_mr_cmd;
        quiet_reset_input_i && !test_select_input_i && !s_q.tm2 &&
        ci_cmd_valid_i && ci_cmd_i == ltm_pkg::CMD_LINE_SILENCE
        ##1 (quiet_reset_input_i && !test_select_input_i && !s_q.tm2 && !ci_cmd_valid_i)
        |=> tx_mute_o && activation_block_o;
    endproperty
    a_mr_cmd: assert property (p_mr_cmd) // see R11, see R3
        else $error("silence command did not enter master reset mode");

    property p_sp_ind;
        test_mode_o == ltm_pkg::MODE_SINGLE_PULSE && $stable(s_q.nt) |->
            ci_override_o &&
            ci_ind_o == (s_q.nt ? ltm_pkg::IND_SHUTDOWN_REQ : ltm_pkg::IND_LINE_IDLE);
    endproperty
    a_sp_ind: assert property (p_sp_ind) // see R4
        else $error("wrong indication in single pulse mode");

    property p_test_ind;
        test_mode_o == ltm_pkg::MODE_MASTER_RESET && $stable(s_q.nt) |->
            ci_override_o &&
            ci_ind_o == (s_q.nt ? ltm_pkg::IND_SHUTDOWN_REQ : ltm_pkg::IND_LINE_IDLE);
    endproperty
    a_test_ind: assert property (p_test_ind) // see R12
        else $error("wrong indication in test state");

    property p_dt_force;
        $rose(test_mode_o == ltm_pkg::MODE_DATA_THROUGH) |->
            force_transparent_o ##1 !force_transparent_o;
    endproperty
    a_dt_force: assert property (p_dt_force) // see R6
        else $error("transparent force missing on data through entry");

    property p_mr_entry;
        $rose(tx_mute_o) |-> coef_clear_o && !tx_single_pulse_o && !wakeup_bypass_o;
    endproperty
    a_mr_entry: assert property (p_mr_entry) // see R9
        else $error("coefficients not cleared on test state entry");

    property p_test_block;
        test_mode_o == ltm_pkg::MODE_MASTER_RESET |-> activation_block_o && tx_mute_o;
    endproperty
    a_test_block: assert property (p_test_block) // see R10
        else $error("activation not refused in test state");

    property p_dt_line;
        test_mode_o == ltm_pkg::MODE_DATA_THROUGH |->
            wakeup_bypass_o && !tx_mute_o && !tx_single_pulse_o && !ci_override_o;
    endproperty
    a_dt_line: assert property (p_dt_line) // see R7
        else $error("data through mode not sending plain scrambled data");

    property p_normal;
        test_mode_o == ltm_pkg::MODE_NORMAL |->
            !tx_mute_o && !tx_single_pulse_o && !wakeup_bypass_o &&
            !ci_override_o && !activation_block_o && !pulse_strobe_o;
    endproperty
    a_normal: assert property (p_normal) // see R13
        else $error("line altered with no test mode chosen");

endmodule

/* File: hdl/ltm_pkg.sv */
// line test mode control: shared constants, register map and types
// assumes a 50 MHz device master clock and a 32-bit APB register bus
package ltm_pkg;

    localparam int          CLK_FREQ_HZ        = 50_000_000;
    localparam real         PULSE_SPACING_MS   = 1.5;
    localparam int          PULSE_SPACING_CYC  = int'(PULSE_SPACING_MS * CLK_FREQ_HZ / 1000.0);
    localparam int          PULSE_CNT_W        = 17;

    // command codes received on the command/indication channel
    localparam logic [3:0]  CMD_SINGLE_PULSE   = 4'h5;
    localparam logic [3:0]  CMD_DATA_THROUGH   = 4'h6;
    localparam logic [3:0]  CMD_LINE_SILENCE   = 4'h1;

    // indication codes sent upstream during test modes
    localparam logic [3:0]  IND_LINE_IDLE      = 4'h0;
    localparam logic [3:0]  IND_SHUTDOWN_REQ   = 4'h8;

    // line levels, two's complement
    localparam logic [2:0]  LEVEL_ZERO         = 3'h0;
    localparam logic [2:0]  LEVEL_PLUS3        = 3'h3;
    localparam logic [2:0]  LEVEL_MINUS3       = 3'h5;

    // register map, byte addresses
    localparam logic [11:0] ADDR_SYSTEM_TEST   = 12'h000;
    localparam logic [11:0] ADDR_STATUS        = 12'h004;

    // system_test_register fields
    localparam int          BIT_TEST_MODE_ONE  = 0;
    localparam int          BIT_TEST_MODE_TWO  = 1;
    localparam int          BIT_NT_CONFIG      = 2;
    localparam logic [2:0]  SYSTEM_TEST_RST    = 3'h0;

    // status fields
    localparam int          STAT_MODE_LSB      = 0;
    localparam int          STAT_BLOCK_BIT     = 2;
    localparam int          STAT_IND_LSB       = 4;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SINGLE_PULSE,
        MODE_DATA_THROUGH,
        MODE_MASTER_RESET
    } ltm_mode_t;

endpackage

/* File: hdl/ltm_pulse_gen.sv */
// line test mode control: isolated alternating pulse generator
// assumes en_i is a level from the mode logic on the same clock
`timescale 1ns/10ps
module ltm_pulse_gen #(
    parameter int PULSE_CYCLES = ltm_pkg::PULSE_SPACING_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       en_i,
    output logic            pulse_o,
    output logic [2:0]      level_o
);

    typedef struct packed {
        logic [ltm_pkg::PULSE_CNT_W-1:0] cnt;
        logic                            neg;
        logic                            pulse;
        logic [2:0]                      level;
    } ltm_pg_state_t;

    localparam logic [ltm_pkg::PULSE_CNT_W-1:0] CNT_LAST =
        ltm_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);

    ltm_pg_state_t s_q;
    ltm_pg_state_t s_d;

    always_comb
    begin
        s_d       = s_q;
        s_d.pulse = 1'b0;
        s_d.level = ltm_pkg::LEVEL_ZERO;
        if (!en_i)
        begin
            s_d.cnt = '0;
            s_d.neg = 1'b0;
        end
        else if (s_q.cnt == CNT_LAST)
        begin
            // one isolated pulse per spacing, polarity alternating
            s_d.cnt   = '0; // see R1
            s_d.pulse = 1'b1;
            s_d.level = s_q.neg ? ltm_pkg::LEVEL_MINUS3 : ltm_pkg::LEVEL_PLUS3; // see R1
            s_d.neg   = ~s_q.neg;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign pulse_o = s_q.pulse;
    assign level_o = s_q.level;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_pulse_spacing;
        pulse_o |-> $past(s_q.cnt) == CNT_LAST && $past(en_i);
    endproperty
    a_pulse_spacing: assert property (p_pulse_spacing) // see R1
        else $error("pulse not at end of spacing interval");

    property p_pulse_alternate;
        pulse_o && en_i |-> s_q.neg != $past(s_q.neg);
    endproperty
    a_pulse_alternate: assert property (p_pulse_alternate) // see R1
        else $error("pulse polarity did not alternate");

    property p_pulse_level;
        pulse_o |-> (level_o == ltm_pkg::LEVEL_PLUS3 || level_o == ltm_pkg::LEVEL_MINUS3);
    endproperty
    a_pulse_level: assert property (p_pulse_level) // see R1
        else $error("pulse level is not plus or minus three");

endmodule

/* File: testbench/ltm_line_partner.sv */
// line test mode control: far-side model, command source and line monitor
// assumes the bench shares clk_i and calls send_cmd right after an edge
`timescale 1ns/10ps
module ltm_line_partner (
    input  wire logic       clk_i,
    input  wire logic       pulse_strobe_i,
    input  wire logic [2:0] pulse_level_i,
    output logic            cmd_valid_o,
    output logic [3:0]      cmd_o,
    output int              pulse_cnt_o,
    output int              gap_o,
    output logic [2:0]      level_o
);
    int         cyc = 0;
    int         last = 0;
    logic       pend = 1'b0;
    logic [3:0] code;

    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_o       = 4'h0;
        pulse_cnt_o = 0;
    end

    // idle code lines carry no value, so they toggle every cycle
    always @(posedge clk_i)
    begin
        cyc         <= cyc + 1;
        cmd_valid_o <= pend;
        cmd_o       <= pend ? code : ~cmd_o;
        if (pulse_strobe_i === 1'b1)
        begin
            pulse_cnt_o <= pulse_cnt_o + 1;
            gap_o       <= cyc - last;
            last        <= cyc;
            level_o     <= pulse_level_i;
        end
    end

    task automatic send_cmd(input logic [3:0] c);
        code <= c;
        pend <= 1'b1;
        @(posedge clk_i);
        pend <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// line test mode control: self-checking bench with a mode reference model
// assumes ltm_top on one 50 MHz clock and the far-side partner model
`timescale 1ns/10ps
module tb_top;
    localparam int PCYC = 16;
    logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rnd, rd;
    logic        q_pin, t_pin, cmd_v, ci_override_o, tx_mute_o, tx_sp_o, strobe_o;
    logic        bypass_o, ft_o, cc_o, block_o, err, mq, mt;
    logic [3:0]  cmd_c, ci_ind_o, cl;
    logic [1:0]  test_mode_o;
    logic [2:0]  level_o, seen_lvl, rb;
    logic [3:0]  codes [4] = '{4'h5, 4'h6, 4'h1, 4'h0};
    int          pcnt, gap, miscompares, n_checks, ft_cnt, cc_cnt, ft_exp, cc_exp;

    ltm_top #(.PULSE_CYCLES(PCYC)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .quiet_reset_input_i(q_pin), .test_select_input_i(t_pin),
        .ci_cmd_valid_i(cmd_v), .ci_cmd_i(cmd_c), .ci_override_o(ci_override_o),
        .ci_ind_o(ci_ind_o), .test_mode_o(test_mode_o), .tx_mute_o(tx_mute_o),
        .tx_single_pulse_o(tx_sp_o), .pulse_strobe_o(strobe_o),
        .pulse_level_o(level_o), .wakeup_bypass_o(bypass_o),
        .force_transparent_o(ft_o), .coef_clear_o(cc_o),
        .activation_block_o(block_o)
    );

    ltm_line_partner part_u (
        .clk_i(clk_i), .pulse_strobe_i(strobe_o), .pulse_level_i(level_o),
        .cmd_valid_o(cmd_v), .cmd_o(cmd_c), .pulse_cnt_o(pcnt), .gap_o(gap),
        .level_o(seen_lvl)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        if (ft_o === 1'b1) ft_cnt++;
        if (cc_o === 1'b1) cc_cnt++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction

    // priority: pins, then register bits, then last command code
    function automatic int exp_mode();
        if (mq && mt) return 1;
        if (!mq && mt) return 2;
        if (!mq && !mt) return 3;
        if (rb[1:0] == 2'b11) return 1;
        if (rb[1:0] == 2'b10) return 2;
        case (cl)
            ltm_pkg::CMD_SINGLE_PULSE: return 1;
            ltm_pkg::CMD_DATA_THROUGH: return 2;
            ltm_pkg::CMD_LINE_SILENCE: return 3;
            default: return 0;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        rd  = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 50) miscompares++;
    endtask

    // entry strobes are expected only when the mode really changes
    task automatic note(input int old);
        int m;
        m = exp_mode();
        if (m != old && m == 2) ft_exp++;
        if (m != old && m == 3) cc_exp++;
    endtask

    task automatic set_pins(input logic q, input logic t);
        int old;
        old = exp_mode();
        @(posedge clk_i);
        mq = q;
        mt = t;
        q_pin <= q;
        t_pin <= t;
        note(old);
    endtask

    task automatic wr_reg(input logic [2:0] v);
        int old;
        old = exp_mode();
        apb(1'b1, ltm_pkg::ADDR_SYSTEM_TEST, {29'h0, v});
        rb = v;
        note(old);
    endtask

    task automatic send(input logic [3:0] c);
        int old;
        old = exp_mode();
        cl = c;
        part_u.send_cmd(c);
        note(old);
    endtask

    task automatic cmp_all();
        int m;
        m = exp_mode();
        apb(1'b0, ltm_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd[2:0], {m == 3, m[1:0]});
        chk("mode", test_mode_o, m);
        chk("mute", tx_mute_o, m == 3);
        chk("single", tx_sp_o, m == 1);
        chk("bypass", bypass_o, m == 2);
        chk("block", block_o, m == 3);
        chk("ovr", ci_override_o, m[0]);
        if (m[0])
            chk("ind", ci_ind_o, rb[2] ? ltm_pkg::IND_SHUTDOWN_REQ : ltm_pkg::IND_LINE_IDLE);
        else
            chk("ind_idle", ci_ind_o, ltm_pkg::IND_LINE_IDLE);
        chk("ft", ft_cnt, ft_exp);
        chk("cc", cc_cnt, cc_exp);
    endtask

    // single pulses entered by pins, command and register bits alike
    task automatic sp_run(input int meth);
        int p0, k;
        set_pins(1'b1, 1'b0);
        wr_reg(3'h0);
        send(4'hf);
        if (meth == 0) set_pins(1'b1, 1'b1);
        else if (meth == 1) send(4'h5);
        else wr_reg(3'h7);
        repeat (4) @(posedge clk_i);
        cmp_all();
        for (int i = 0; i < 3; i++)
        begin
            p0 = pcnt;
            k = 0;
            while (pcnt == p0 && k < 100)
            begin
                @(posedge clk_i);
                k++;
            end
            chk("pulse", k < 100, 1'b1);
            chk("level", seen_lvl, i == 1 ? ltm_pkg::LEVEL_MINUS3 : ltm_pkg::LEVEL_PLUS3);
            if (i > 0) chk("gap", gap, PCYC);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        {srst_i, q_pin, mq} = 3'b111;
        {psel_i, penable_i, pwrite_i, t_pin, mt} = 5'b0;
        paddr_i = 12'h0;
        pwdata_i = 32'h0;
        {rb, cl} = 7'h0;
        {miscompares, n_checks, ft_cnt, cc_cnt, ft_exp, cc_exp} = '0;
        rnd = 32'h7204ddbe;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        apb(1'b0, ltm_pkg::ADDR_SYSTEM_TEST, 32'h0);
        chk("stest_rst", rd, {29'h0, ltm_pkg::SYSTEM_TEST_RST});
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        apb(1'b1, ltm_pkg::ADDR_STATUS, 32'hff);
        cmp_all();
        for (int m = 0; m < 3; m++)
            sp_run(m);
        for (int i = 0; i < 60; i++)
        begin
            rnd = lfsr(rnd);
            case (rnd[1:0])
                2'd0: set_pins(rnd[2], rnd[3]);
                2'd1: wr_reg(rnd[6:4]);
                default: send(rnd[13] ? rnd[11:8] : codes[rnd[15:14]]);
            endcase
            repeat (4) @(posedge clk_i);
            cmp_all();
        end
        tally_and_finish();
    end
endmodule
